// [test_wiring_and_accumulation_config.sv]
// Self-checking bench for the wiring and accumulation configuration block
`timescale 1ns/10ps
module test_wiring_and_accumulation_config;
	import wac_pkg::*;
	localparam int W = 24;
	logic core_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, sample_valid_i = 1'b0;
	logic [11:0] reg_addr_i = 12'h000;
	logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, cfg, det;
	logic signed [W-1:0] vi [6], pi [4], e [6]; // Channels A,B,C then IA,IB,IC
	wire logic signed [W-1:0] vo [6], po [4]; // Nets, since output ports drive them
	logic valid_o, freq_o;
	logic [31:0] per_o;
	logic [3:0] oc_o;
	logic [2:0] pk_o;
	int err_total = 0, n_tests = 0, seed = 32'h7d2670e8;
	always #2 core_clk_i = ~core_clk_i; // 250 MHz
	wiring_and_accumulation_config #(.W(W)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i), .va_i(vi[0]), .vb_i(vi[1]),
		.vc_i(vi[2]), .ia_i(vi[3]), .ib_i(vi[4]), .ic_i(vi[5]), .p_tot_i(pi[0]), .p_fund_i(pi[1]),
		.q_tot_i(pi[2]), .q_fund_i(pi[3]), .sample_valid_o(valid_o), .va_o(vo[0]), .vb_o(vo[1]),
		.vc_o(vo[2]), .ia_o(vo[3]), .ib_o(vo[4]), .ic_o(vo[5]), .p_tot_o(po[0]), .p_fund_o(po[1]),
		.q_tot_o(po[2]), .q_fund_o(po[3]), .line_frequency_select_o(freq_o),
		.default_period_o(per_o), .overcurrent_enable_o(oc_o), .peak_phase_select_o(pk_o));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Write, then idle two cycles so configuration outputs settle
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(negedge core_clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge core_clk_i);
		reg_wr_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] x);
		@(negedge core_clk_i);
		reg_addr_i = a;
		@(negedge core_clk_i);
		chk(reg_rdata_o, x);
	endtask
	// Accumulation shaping; most negative saturates under absolute mode
	function automatic logic signed [W-1:0] shp(input logic signed [W-1:0] x, input logic [1:0] m);
		case (m)
			2'h1: return (x == 24'h800000) ? 24'h7fffff : ((x < 0) ? -x : x);
			2'h2: return (x < 0) ? 24'h000000 : x;
			2'h3: return (x < 0) ? x : 24'h000000;
			default: return x;
		endcase
	endfunction
	// Watchdog: the sequence needs about 700 cycles
	initial begin
		#200000;
		err_total++;
		summarize();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		foreach (vi[k]) vi[k] = '0;
		foreach (pi[k]) pi[k] = '0;
		repeat (6) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		rd(ACC_WIRE_ADDR, 16'h0000);
		rd(DET_EN_ADDR, 16'hf000);
		chk(oc_o, 4'hf);
		chk(per_o, PERIOD_60_CYC);
		for (int i = 0; i < 48; i++) begin
			cfg = $random(seed);
			if (i < 8) cfg[6:4] = i[2:0]; // Every topology code, reserved ones too
			if (i < 4) cfg[3:0] = {i[1:0], i[1:0]}; // Every accumulation mode
			wr(ACC_WIRE_ADDR, cfg);
			rd(ACC_WIRE_ADDR, cfg & ACC_WIRE_MASK);
			chk(freq_o, cfg[FREQ_BIT]);
			chk(per_o, cfg[FREQ_BIT] ? PERIOD_50_CYC : PERIOD_60_CYC);
			foreach (vi[k]) vi[k] = $random(seed);
			foreach (pi[k]) pi[k] = $random(seed);
			if (i % 4 == 0) pi[(i / 4) % 4] = 24'h800000; // Saturation corner
			if (i % 4 == 1) pi[(i / 4) % 4] = 24'h000000; // Zero corner
			@(negedge core_clk_i);
			sample_valid_i = 1'b1;
			@(negedge core_clk_i);
			sample_valid_i = 1'b0;
			chk(valid_o, 1'b1);
			e = vi;
			case (cfg[6:4])
				3'h1: e[1] = vi[0] - vi[2];
				3'h2: e[1] = -vi[0] - vi[2];
				3'h3: e[1] = -vi[0];
				3'h4: begin
					e[0] = vi[0] - vi[1];
					e[1] = vi[0] - vi[2];
					e[2] = vi[2] - vi[1];
				end
				default: ;
			endcase
			if (cfg[DERIVE_IB_BIT]) e[4] = -vi[3] - vi[5];
			foreach (vo[k]) chk(vo[k], e[k]);
			// Active powers follow bits 1:0, reactive powers bits 3:2
			for (int k = 0; k < 2; k++) chk(po[k], shp(pi[k], cfg[1:0]));
			for (int k = 2; k < 4; k++) chk(po[k], shp(pi[k], cfg[3:2]));
			det = $random(seed);
			wr(DET_EN_ADDR, det);
			rd(DET_EN_ADDR, det & DET_EN_MASK);
			chk(oc_o, det[15:12]);
			chk(pk_o, det[4:2]);
			$display("test %0d done", i);
		end
		// Mid-run reset: both registers and the outputs built from them come back
		@(negedge core_clk_i);
		rst_n_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		chk(oc_o, 4'hf);
		chk(pk_o, 3'h0);
		chk(freq_o, 1'b0);
		chk(per_o, PERIOD_60_CYC);
		rd(ACC_WIRE_ADDR, 16'h0000);
		rd(DET_EN_ADDR, 16'hf000);
		wr(12'h494, 16'hffff);
		rd(12'h494, 16'h0000);
		summarize();
	end
endmodule // test_wiring_and_accumulation_config

// [wac_accum_shaper.sv]
// Combinational accumulation-mode shaper for one power sample
`timescale 1ns/10ps
module wac_accum_shaper
	import wac_pkg::*;
#(
	parameter int W = 24
) (
	wac_sample_if.shp s
);
	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	// Absolute of the most negative value saturates rather than wraps
	always_comb begin
		case (accum_t'(s.mode))
			ACC_SIGNED: s.shaped = s.raw;
			ACC_ABS: begin
				if (s.raw == {1'b1, {(W-1){1'b0}}}) begin
					s.shaped = {1'b0, {(W-1){1'b1}}};
				end else begin
					s.shaped = s.raw[W-1] ? -s.raw : s.raw;
				end
			end
			ACC_POS: s.shaped = s.raw[W-1] ? '0 : s.raw;
			default: s.shaped = s.raw[W-1] ? s.raw : '0;
		endcase
	end
endmodule // wac_accum_shaper

// [wac_checker.sv]
// Concurrent checks on the ports of the wiring and accumulation configuration block
`timescale 1ns/10ps
module wac_checker
	import wac_pkg::*;
#(
	parameter int W = 24
) (
	// Clock, reset and register port
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	// Sample path
	input wire logic sample_valid_i,
	input wire logic sample_valid_o,
	input wire logic signed [W-1:0] p_tot_i,
	input wire logic signed [W-1:0] p_tot_o,
	// Configuration outputs
	input wire logic line_frequency_select_o,
	input wire logic [31:0] default_period_o,
	input wire logic [3:0] overcurrent_enable_o,
	input wire logic [2:0] peak_phase_select_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// ----------------------------------------
	// Helper: last written word
	// ----------------------------------------
	logic [15:0] wd_r; // Held so checks two edges later still see the written value
	always_ff @(posedge core_clk_i) begin
		if (reg_wr_i) begin
			wd_r <= reg_wdata_i;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_FREQ: assert property (reg_wr_i && reg_addr_i == ACC_WIRE_ADDR ##1 !reg_wr_i
		|-> ##1 line_frequency_select_o == wd_r[FREQ_BIT]) else $error("frequency select wrong");
	AST_PERIOD: assert property ($stable(line_frequency_select_o) |-> default_period_o
		== (line_frequency_select_o ? PERIOD_50_CYC : PERIOD_60_CYC)) else $error("period wrong");
	AST_OC: assert property (reg_wr_i && reg_addr_i == DET_EN_ADDR ##1 !reg_wr_i
		|-> ##1 overcurrent_enable_o == wd_r[15:12]) else $error("overcurrent enable wrong");
	AST_PEAK: assert property (reg_wr_i && reg_addr_i == DET_EN_ADDR ##1 !reg_wr_i
		|-> ##1 peak_phase_select_o == wd_r[4:2]) else $error("peak select wrong");
	AST_RSV_ACC: assert property (reg_addr_i == ACC_WIRE_ADDR |=>
		reg_rdata_o[15:9] == 7'h00) else $error("accumulation reserved bits nonzero");
	AST_RSV_DET: assert property (reg_addr_i == DET_EN_ADDR |=>
		reg_rdata_o[11:5] == 7'h00 && reg_rdata_o[1:0] == 2'h0) else $error("detect reserved nonzero");
	AST_UNMAPPED: assert property (reg_addr_i != ACC_WIRE_ADDR
		&& reg_addr_i != DET_EN_ADDR |=> reg_rdata_o == 16'h0000) else $error("unmapped read nonzero");
	AST_VALID: assert property (sample_valid_i |=> sample_valid_o)
		else $error("sample valid not delayed");
	AST_POS: assert property (sample_valid_i && p_tot_i > 0 |=>
		p_tot_o == $past(p_tot_i) || p_tot_o == '0) else $error("positive power altered");
endmodule // wac_checker
bind wiring_and_accumulation_config wac_checker #(.W(W)) u_chk (.core_clk_i, .rst_n_i,
	.reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .sample_valid_i, .sample_valid_o,
	.p_tot_i, .p_tot_o, .line_frequency_select_o, .default_period_o, .overcurrent_enable_o,
	.peak_phase_select_o);

// [wac_pkg.sv]
// Package with register map, field layout, codes and reset values of the configuration block
package wac_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [11:0] ACC_WIRE_ADDR = 12'h492; // accumulation_wiring_config
	localparam logic [11:0] DET_EN_ADDR = 12'h493; // detection_enable_config
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int FREQ_BIT = 8;
	localparam int DERIVE_IB_BIT = 7;
	localparam int TOPO_LSB = 4;
	localparam int REACT_LSB = 2;
	localparam int ACTIVE_LSB = 0;
	localparam int OC_LSB = 12;
	localparam int PEAK_LSB = 2;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] ACC_WIRE_RST = 16'h0000;
	localparam logic [15:0] DET_EN_RST = 16'hf000;
	localparam logic [15:0] ACC_WIRE_MASK = 16'h01ff; // Writable bits
	localparam logic [15:0] DET_EN_MASK = 16'hf01c;
	// ------------------------------------------------------------
	// Wiring topology codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TOPO_WYE4 = 3'h0,
		TOPO_DELTA3_B = 3'h1,
		TOPO_WYE4_NB = 3'h2,
		TOPO_DELTA4_NB = 3'h3,
		TOPO_DELTA3_ALL = 3'h4
	} topo_t;
	// Accumulation modes
	typedef enum logic [1:0] {
		ACC_SIGNED = 2'h0,
		ACC_ABS = 2'h1,
		ACC_POS = 2'h2,
		ACC_NEG = 2'h3
	} accum_t;
	// Default line periods, in clock cycles at 250 MHz
	localparam int CLK_HZ = 250_000_000;
	localparam int PERIOD_50_CYC = CLK_HZ / 50;
	localparam int PERIOD_60_CYC = CLK_HZ / 60;
endpackage

// [wac_sample_if.sv]
// Interface carrying one signed power sample between the configuration block and an accumulation shaper
`timescale 1ns/10ps
interface wac_sample_if #(parameter int W = 24);
	logic signed [W-1:0] raw; // Incoming power sample
	logic [1:0] mode; // Accumulation mode
	logic signed [W-1:0] shaped; // Sample to accumulate
	modport src (output raw, output mode, input shaped);
	modport shp (input raw, input mode, output shaped);
endinterface // wac_sample_if

// [wiring_and_accumulation_config.sv]
// Wiring derivation and accumulation configuration block with its two registers
`timescale 1ns/10ps
// Behaviour
// - Frequency bit: one selects 50 Hz
// - Derived current: IB equals minus IA minus IC
// - Topology 000 wye, 001 and 100 delta
// - Code 010: VB becomes minus VA minus VC
// - Code 011: VB becomes minus VA
// - Reactive mode covers total and fundamental
// - Modes: signed, absolute, positive, negative
// - Active mode same codes, total and fundamental
// - Overcurrent enables reset to all ones
// - Enable bits 12..15 are A, B, C, N
// - Peak detection enables per phase A, B, C
module wiring_and_accumulation_config
	import wac_pkg::*;
#(
	parameter int W = 24 // Sample width
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Register access port
	input wire logic [11:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	// Measured samples
	input wire logic sample_valid_i,
	input wire logic signed [W-1:0] va_i,
	input wire logic signed [W-1:0] vb_i,
	input wire logic signed [W-1:0] vc_i,
	input wire logic signed [W-1:0] ia_i,
	input wire logic signed [W-1:0] ib_i,
	input wire logic signed [W-1:0] ic_i,
	// Power samples: total/fundamental, active/reactive
	input wire logic signed [W-1:0] p_tot_i,
	input wire logic signed [W-1:0] p_fund_i,
	input wire logic signed [W-1:0] q_tot_i,
	input wire logic signed [W-1:0] q_fund_i,
	// Derived channels
	output logic sample_valid_o,
	output logic signed [W-1:0] va_o,
	output logic signed [W-1:0] vb_o,
	output logic signed [W-1:0] vc_o,
	output logic signed [W-1:0] ia_o,
	output logic signed [W-1:0] ib_o,
	output logic signed [W-1:0] ic_o,
	// Shaped power for energy registers and pulse outputs
	output logic signed [W-1:0] p_tot_o,
	output logic signed [W-1:0] p_fund_o,
	output logic signed [W-1:0] q_tot_o,
	output logic signed [W-1:0] q_fund_o,
	// Configuration to neighbouring blocks
	output logic line_frequency_select_o,
	output logic [31:0] default_period_o,
	output logic [3:0] overcurrent_enable_o,
	output logic [2:0] peak_phase_select_o
);
	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	if (W < 4 || W > 64) begin : g_bad_w
		$error("Sample width out of range");
	end

	logic [15:0] acc_wire_r; // accumulation_wiring_config
	logic [15:0] det_en_r; // detection_enable_config
	logic [15:0] rdata_nxt; // Read mux
	logic signed [W-1:0] va_nxt, vb_nxt, vc_nxt, ib_nxt; // Derived channels
	logic line_frequency_select; // One is 50 Hz
	logic derive_phase_b_current;
	logic [2:0] wiring_topology_select;
	logic [1:0] reactive_accum_mode;
	logic [1:0] active_accum_mode;

	assign line_frequency_select = acc_wire_r[FREQ_BIT];
	assign derive_phase_b_current = acc_wire_r[DERIVE_IB_BIT];
	assign wiring_topology_select = acc_wire_r[TOPO_LSB +: 3];
	assign reactive_accum_mode = acc_wire_r[REACT_LSB +: 2];
	assign active_accum_mode = acc_wire_r[ACTIVE_LSB +: 2];

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Masks keep reserved bits at zero in storage
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			acc_wire_r <= ACC_WIRE_RST;
		end else if (reg_wr_i && reg_addr_i == ACC_WIRE_ADDR) begin
			acc_wire_r <= reg_wdata_i & ACC_WIRE_MASK;
		end
	end

	// Overcurrent enables come up all set
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			det_en_r <= DET_EN_RST;
		end else if (reg_wr_i && reg_addr_i == DET_EN_ADDR) begin
			det_en_r <= reg_wdata_i & DET_EN_MASK;
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	// Unmapped addresses read zero
	always_comb begin
		if (reg_addr_i == ACC_WIRE_ADDR) begin
			rdata_nxt = acc_wire_r;
		end else if (reg_addr_i == DET_EN_ADDR) begin
			rdata_nxt = det_en_r;
		end else begin
			rdata_nxt = 16'h0000;
		end
	end

	// Registered read data, one cycle after the address
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 16'h0000;
		end else begin
			reg_rdata_o <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// Configuration outputs
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			line_frequency_select_o <= 1'b0;
			default_period_o <= 32'(PERIOD_60_CYC);
			overcurrent_enable_o <= DET_EN_RST[OC_LSB +: 4];
			peak_phase_select_o <= 3'h0;
		end else begin
			line_frequency_select_o <= line_frequency_select;
			// Zero selects 60 Hz period when no zero crossing is seen
			default_period_o <= line_frequency_select ? 32'(PERIOD_50_CYC)
				: 32'(PERIOD_60_CYC);
			// Bit 0 of this output is phase A (register bit 12), bit 3 neutral
			overcurrent_enable_o <= det_en_r[OC_LSB +: 4];
			peak_phase_select_o <= det_en_r[PEAK_LSB +: 3];
		end
	end

	// ------------------------------------------------------------
	// Channel derivation
	// ------------------------------------------------------------
	// Sums wrap at sample width; callers keep headroom in the samples
	always_comb begin
		va_nxt = va_i;
		vb_nxt = vb_i;
		vc_nxt = vc_i;
		case (topo_t'(wiring_topology_select))
			TOPO_WYE4: vb_nxt = vb_i;
			TOPO_DELTA3_B: vb_nxt = va_i - vc_i;
			TOPO_WYE4_NB: vb_nxt = -va_i - vc_i;
			TOPO_DELTA4_NB: vb_nxt = -va_i;
			TOPO_DELTA3_ALL: begin
				va_nxt = va_i - vb_i;
				vb_nxt = va_i - vc_i;
				vc_nxt = vc_i - vb_i;
			end
			default: vb_nxt = vb_i; // Undefined codes pass as measured
		endcase
		ib_nxt = derive_phase_b_current ? (-ia_i - ic_i) : ib_i;
	end

	// ------------------------------------------------------------
	// Accumulation shaping
	// ------------------------------------------------------------
	wac_sample_if #(.W(W)) s_pt ();
	wac_sample_if #(.W(W)) s_pf ();
	wac_sample_if #(.W(W)) s_qt ();
	wac_sample_if #(.W(W)) s_qf ();
	assign s_pt.raw = p_tot_i;
	assign s_pf.raw = p_fund_i;
	assign s_qt.raw = q_tot_i;
	assign s_qf.raw = q_fund_i;
	assign s_pt.mode = active_accum_mode;
	assign s_pf.mode = active_accum_mode;
	assign s_qt.mode = reactive_accum_mode;
	assign s_qf.mode = reactive_accum_mode;
	wac_accum_shaper #(.W(W)) u_pt (.s(s_pt.shp));
	wac_accum_shaper #(.W(W)) u_pf (.s(s_pf.shp));
	wac_accum_shaper #(.W(W)) u_qt (.s(s_qt.shp));
	wac_accum_shaper #(.W(W)) u_qf (.s(s_qf.shp));

	// ------------------------------------------------------------
	// Output stage
	// ------------------------------------------------------------
	// Data registers load only with a valid sample, keeping stale values stable
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sample_valid_o <= 1'b0;
			va_o <= '0;
			vb_o <= '0;
			vc_o <= '0;
			ia_o <= '0;
			ib_o <= '0;
			ic_o <= '0;
			p_tot_o <= '0;
			p_fund_o <= '0;
			q_tot_o <= '0;
			q_fund_o <= '0;
		end else begin
			sample_valid_o <= sample_valid_i;
			if (sample_valid_i) begin
				va_o <= va_nxt;
				vb_o <= vb_nxt;
				vc_o <= vc_nxt;
				ia_o <= ia_i;
				ib_o <= ib_nxt;
				ic_o <= ic_i;
				p_tot_o <= s_pt.shaped;
				p_fund_o <= s_pf.shaped;
				q_tot_o <= s_qt.shaped;
				q_fund_o <= s_qf.shaped;
			end
		end
	end
endmodule // wiring_and_accumulation_config
